// ===== logic/fesrm_regs.sv
// erase block selection and ram emulation mapping registers, axi4-lite slave
// Notes on behaviour
// R1: in flash-enabled modes every erase selection register resets to all zeros.
// R2: split variant, flash disabled: writes ignored, selection registers read all ones.
// R3: single-register variant, rom disabled: writes ignored, register reads all zeros.
// R4: select bit zero keeps ram at normal area, no emulation, area bits ignored.
// R5: upper four mapping bits are fixed ones, software cannot change them.
// R6: software must not write data into the upper four reserved mapping bits.
// R7: mapping bit zero is a reserved read/write storage bit resetting to zero.
// R8: each selection bit marks one flash block; one selects, zero protects.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module fesrm_regs
#(
  // 1: separate large and small selection registers; 0: single erase enable register
  parameter bit SPLIT_VARIANT = 1'b1
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // operating mode pins
  input wire logic [2:0] op_mode_i,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // block selection and mapping outputs
  output logic [7:0] large_block_select_o,
  output logic [7:0] small_block_select_o,
  output logic emulation_active_o,
  output logic [23:0] ram_window_base_o
);
  typedef struct packed {
    logic aw_held;
    logic [9:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] large_sel;
    logic [7:0] small_sel;
    logic map_sel;
    logic map_hi;
    logic map_lo;
    logic map_rsvd0;
    logic flash_en;
    logic emu_active;
    logic [23:0] win_base;
    logic [7:0] large_out;
    logic [7:0] small_out;
  } fesrm_state_type;

  fesrm_state_type st_reg;
  fesrm_state_type st_next;
  logic [2:0] mode_sync;
  logic flash_mode;
  logic do_write;
  logic wr_lane0;
  logic [7:0] map_read;
  logic [7:0] large_read;
  logic [7:0] small_read;

  // mode pins come from outside the clock domain
  fesrm_sync #(.WIDTH(3)) u_mode_sync
  (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i(op_mode_i),
    .settled_o(mode_sync)
  );

  assign flash_mode = (mode_sync >= fesrm_pkg::FLASH_MODE_MIN);
  assign do_write = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
  assign wr_lane0 = st_reg.w_strb[0];

  // read views; locked registers show their fixed pattern
  always_comb
  begin
    map_read = {fesrm_pkg::MAP_RSVD_VALUE, st_reg.map_sel, st_reg.map_hi, st_reg.map_lo,
                st_reg.map_rsvd0}; // R5
    if (st_reg.flash_en)
    begin
      large_read = st_reg.large_sel;
      small_read = st_reg.small_sel;
    end
    else if (SPLIT_VARIANT)
    begin
      large_read = fesrm_pkg::SEL_READ_LOCKED_SPLIT; // R2
      small_read = fesrm_pkg::SEL_READ_LOCKED_SPLIT; // R2
    end
    else
    begin
      large_read = fesrm_pkg::SEL_READ_LOCKED_SINGLE; // R3
      small_read = fesrm_pkg::SEL_READ_LOCKED_SINGLE;
    end
  end

  // next-state logic for bus, registers and mapping
  always_comb
  begin
    st_next = st_reg;
    st_next.flash_en = flash_mode;
    // write address and data taken independently, held until response
    if (s_axi_awvalid && !st_reg.aw_held)
    begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr[9:0];
    end
    if (s_axi_wvalid && !st_reg.w_held)
    begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      st_next.bvalid = 1'b1;
      st_next.bresp = fesrm_pkg::RESP_OKAY;
      unique case (st_reg.aw_addr)
        fesrm_pkg::LARGE_SEL_ADDR:
        begin
          // writes dropped while flash is off; one bit per block
          if (st_reg.flash_en && wr_lane0) // R2 R3
          begin
            st_next.large_sel = st_reg.w_data[7:0]; // R8
          end
        end
        fesrm_pkg::SMALL_SEL_ADDR:
        begin
          if (!SPLIT_VARIANT)
          begin
            st_next.bresp = fesrm_pkg::RESP_SLVERR;
          end
          else if (st_reg.flash_en && wr_lane0) // R2
          begin
            st_next.small_sel = st_reg.w_data[7:0]; // R8
          end
        end
        fesrm_pkg::RAM_MAP_ADDR:
        begin
          // mapping bits writable only with flash on; bit 0 is plain storage
          if (st_reg.flash_en && wr_lane0)
          begin
            st_next.map_sel = st_reg.w_data[fesrm_pkg::MAP_SEL_BIT];
            st_next.map_hi = st_reg.w_data[fesrm_pkg::MAP_HI_BIT];
            st_next.map_lo = st_reg.w_data[fesrm_pkg::MAP_LO_BIT];
            st_next.map_rsvd0 = st_reg.w_data[fesrm_pkg::MAP_RSVD0_BIT]; // R7
          end
        end
        fesrm_pkg::MODE_STATUS_ADDR:
        begin
          st_next.bresp = fesrm_pkg::RESP_OKAY;
        end
        default:
        begin
          st_next.bresp = fesrm_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready)
    begin
      st_next.bvalid = 1'b0;
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
    end
    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && !st_reg.rvalid)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = fesrm_pkg::RESP_OKAY;
      st_next.rdata = 32'h0000_0000;
      unique case (s_axi_araddr[9:0])
        fesrm_pkg::LARGE_SEL_ADDR: st_next.rdata = {24'h00_0000, large_read};
        fesrm_pkg::SMALL_SEL_ADDR:
        begin
          if (SPLIT_VARIANT)
          begin
            st_next.rdata = {24'h00_0000, small_read};
          end
          else
          begin
            st_next.rresp = fesrm_pkg::RESP_SLVERR;
          end
        end
        fesrm_pkg::RAM_MAP_ADDR: st_next.rdata = {24'h00_0000, map_read};
        fesrm_pkg::MODE_STATUS_ADDR: st_next.rdata = {28'h000_0000, st_reg.flash_en, mode_sync};
        default: st_next.rresp = fesrm_pkg::RESP_SLVERR;
      endcase
    end
    else if (st_reg.rvalid && s_axi_rready)
    begin
      st_next.rvalid = 1'b0;
    end
    // leaving flash mode clears selection so no block stays chosen
    if (!st_reg.flash_en)
    begin
      st_next.large_sel = fesrm_pkg::SEL_RESET; // R1
      st_next.small_sel = fesrm_pkg::SEL_RESET; // R1
      st_next.map_sel = 1'b0;
      st_next.map_hi = 1'b0;
      st_next.map_lo = 1'b0;
    end
    // emulation window: select off means normal ram area whatever the area bits
    st_next.emu_active = st_reg.map_sel; // R4
    if (st_reg.map_sel)
    begin
      st_next.win_base = fesrm_pkg::EMU_WINDOW_SIZE * {22'h0, st_reg.map_hi, st_reg.map_lo};
    end
    else
    begin
      st_next.win_base = fesrm_pkg::RAM_NORMAL_BASE; // R4
    end
    st_next.large_out = st_reg.flash_en ? st_reg.large_sel : fesrm_pkg::SEL_RESET;
    st_next.small_out = (st_reg.flash_en && SPLIT_VARIANT) ? st_reg.small_sel : fesrm_pkg::SEL_RESET;
  end

  // single state register; reset puts every selection at zero
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
      st_reg.large_sel <= fesrm_pkg::SEL_RESET; // R1
      st_reg.small_sel <= fesrm_pkg::SEL_RESET; // R1
      st_reg.map_rsvd0 <= 1'b0; // R7
      st_reg.win_base <= fesrm_pkg::RAM_NORMAL_BASE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = !st_reg.aw_held;
  assign s_axi_wready = !st_reg.w_held;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
  assign large_block_select_o = st_reg.large_out;
  assign small_block_select_o = st_reg.small_out;
  assign emulation_active_o = st_reg.emu_active;
  assign ram_window_base_o = st_reg.win_base;

  // assertions
  a_locked_reads_ff: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R2
    (SPLIT_VARIANT && !st_reg.flash_en) |-> (large_read == 8'hff && small_read == 8'hff))
    else $error("locked selection does not read all ones");
  a_single_reads_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R3
    (!SPLIT_VARIANT && !st_reg.flash_en) |-> (large_read == 8'h00))
    else $error("locked enable register does not read zero");
  a_locked_no_write: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R2
    (!st_reg.flash_en && !flash_mode) |=> (st_reg.large_sel == 8'h00 && st_reg.small_sel == 8'h00))
    else $error("selection changed while flash disabled");
  a_reset_zero_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R1
    $past(rst_i) |-> (st_reg.large_sel == 8'h00 && st_reg.small_sel == 8'h00))
    else $error("selection not zero after reset");
  a_no_emu_normal: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R4
    !st_reg.map_sel |=> (!emulation_active_o && ram_window_base_o == 24'hfff000))
    else $error("emulation with select bit clear");
  a_emu_window_base: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R4
    st_reg.map_sel |=> (ram_window_base_o == {12'h000, $past(st_reg.map_hi), $past(st_reg.map_lo), 10'h000}))
    else $error("wrong emulation window");
  a_map_upper_ones: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R5
    map_read[7:4] == 4'hf)
    else $error("upper mapping bits not ones");
  a_rsvd0_stores: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R7
    (do_write && st_reg.flash_en && wr_lane0 && st_reg.aw_addr == 10'h11c)
    |=> (st_reg.map_rsvd0 == $past(st_reg.w_data[0])))
    else $error("mapping bit 0 not stored");
  a_sel_follows_write: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R8
    (do_write && st_reg.flash_en && flash_mode && wr_lane0 && st_reg.aw_addr == 10'h108)
    |=> ##1 (large_block_select_o == $past(st_reg.w_data[7:0], 2)))
    else $error("block selection output mismatch");
endmodule : fesrm_regs

// ===== logic/fesrm_pkg.sv
// package: offsets, field positions, reset values and mapping constants
package fesrm_pkg;
  // register byte offsets (printed offsets are not all multiples of four: index * 4)
  localparam logic [7:0] LARGE_SEL_IDX = 8'h42;
  localparam logic [7:0] SMALL_SEL_IDX = 8'h43;
  localparam logic [7:0] RAM_MAP_IDX = 8'h47;
  localparam logic [9:0] LARGE_SEL_ADDR = {LARGE_SEL_IDX, 2'b00};
  localparam logic [9:0] SMALL_SEL_ADDR = {SMALL_SEL_IDX, 2'b00};
  localparam logic [9:0] RAM_MAP_ADDR = {RAM_MAP_IDX, 2'b00};
  localparam logic [9:0] MODE_STATUS_ADDR = 10'h200;
  // reset and forced read values
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] SEL_READ_LOCKED_SPLIT = 8'hff;
  localparam logic [7:0] SEL_READ_LOCKED_SINGLE = 8'h00;
  localparam logic [3:0] MAP_RSVD_VALUE = 4'hf;
  localparam logic [3:0] MAP_LOW_RESET = 4'h0;
  // ram mapping field positions
  localparam int MAP_SEL_BIT = 3;
  localparam int MAP_HI_BIT = 2;
  localparam int MAP_LO_BIT = 1;
  localparam int MAP_RSVD0_BIT = 0;
  // address windows
  localparam logic [23:0] RAM_NORMAL_BASE = 24'hfff000;
  localparam logic [23:0] RAM_NORMAL_TOP = 24'hfff3ff;
  localparam logic [23:0] EMU_WINDOW_SIZE = 24'h000400;
  // first mode with on-chip flash enabled
  localparam logic [2:0] FLASH_MODE_MIN = 3'h5;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : fesrm_pkg

// ===== logic/fesrm_sync.sv
// three-stage input synchroniser with agreement check
`timescale 1ns/1ps
module fesrm_sync
#(
  parameter int WIDTH = 3
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // asynchronous input and settled output
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] settled_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } fesrm_sync_type;
  fesrm_sync_type st_reg;
  fesrm_sync_type st_next;

  // first stage feeds only the second; change counts once stages two and three agree
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = async_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3)
    begin
      st_next.out = st_reg.s3;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign settled_o = st_reg.out;
endmodule : fesrm_sync

// ===== testbench/fesrm_bench.sv
// self-checking bench for the erase selection and ram mapping registers
`timescale 1ns/1ps
module fesrm_bench;
  // clock, reset and mode pins
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] op_mode_i = 3'h2;
  // shared axi master side
  logic [31:0] s_axi_awaddr = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  // slave answers, split variant then single variant
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, emu_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp_1, rresp_1;
  logic [31:0] s_axi_rdata, rdata_1;
  logic [7:0] large_o, small_o, large_1;
  logic [23:0] base_o;
  logic [31:0] rd_split, rd_single;
  int num_errors = 0;
  int tests_run = 0;

  // both variants see the same bus, so their timing matches
  fesrm_regs #(.SPLIT_VARIANT(1'b1)) u_fesrm_regs (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .op_mode_i(op_mode_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .large_block_select_o(large_o), .small_block_select_o(small_o), .emulation_active_o(emu_o),
    .ram_window_base_o(base_o));
  fesrm_regs #(.SPLIT_VARIANT(1'b0)) u_fesrm_regs_single (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .op_mode_i(op_mode_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
    .s_axi_bresp(bresp_1), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
    .s_axi_rdata(rdata_1), .s_axi_rresp(rresp_1), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
    .large_block_select_o(large_1), .small_block_select_o(), .emulation_active_o(), .ram_window_base_o());

  // 100 ns clock
  always #50 sys_clk_i = ~sys_clk_i;

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t response %h expected %h", $time, got, exp);
    end
  endtask : check_resp

  // address and data offered together, each released once taken
  task automatic wr(input logic [9:0] addr, input logic [7:0] data, input logic [3:0] strb);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= {22'h0, addr};
    s_axi_wdata <= {24'h0, data};
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk_i);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!(aw_done && w_done && s_axi_bvalid));
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] addr);
    s_axi_araddr <= {22'h0, addr};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk_i);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd_split = s_axi_rdata;
    rd_single = rdata_1;
    s_axi_rready <= 1'b0;
  endtask : rd

  // read, then compare both variants against their expected words
  task automatic rd_check(input logic [9:0] addr, input logic [7:0] exp_split, input logic [7:0] exp_single);
    rd(addr);
    check_resp(s_axi_rresp, fesrm_pkg::RESP_OKAY);
    check_val(rd_split, {24'h0, exp_split});
    check_val(rd_single, {24'h0, exp_single});
  endtask : rd_check

  // restart with the mode pins already steady, then let the synchroniser settle
  task automatic restart(input logic [2:0] mode);
    op_mode_i <= mode;
    rst_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
  endtask : restart

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // main sequence
  initial
  begin
    restart(3'h2);
    rd_check(fesrm_pkg::LARGE_SEL_ADDR, 8'hff, 8'h00);
    wr(fesrm_pkg::LARGE_SEL_ADDR, 8'h5a, 4'h1);
    rd_check(fesrm_pkg::LARGE_SEL_ADDR, 8'hff, 8'h00);
    rd(fesrm_pkg::SMALL_SEL_ADDR);
    check_val(rd_split, 32'h0000_00ff);
    check_val({16'h0, large_o, small_o}, 32'h0);
    $display("test flash_off done");
    restart(3'h6);
    rd_check(fesrm_pkg::LARGE_SEL_ADDR, 8'h00, 8'h00);
    rd(fesrm_pkg::SMALL_SEL_ADDR);
    check_val(rd_split, 32'h0);
    check_resp(rresp_1, fesrm_pkg::RESP_SLVERR);
    rd_check(fesrm_pkg::RAM_MAP_ADDR, 8'hf0, 8'hf0);
    wr(fesrm_pkg::LARGE_SEL_ADDR, 8'ha5, 4'h1);
    repeat (2) @(posedge sys_clk_i);
    check_val({large_o, large_1}, 32'h0000_a5a5);
    wr(fesrm_pkg::LARGE_SEL_ADDR, 8'h00, 4'h0);
    rd_check(fesrm_pkg::LARGE_SEL_ADDR, 8'ha5, 8'ha5);
    wr(fesrm_pkg::SMALL_SEL_ADDR, 8'h3c, 4'h1);
    check_resp(s_axi_bresp, fesrm_pkg::RESP_OKAY);
    check_resp(bresp_1, fesrm_pkg::RESP_SLVERR);
    repeat (2) @(posedge sys_clk_i);
    check_val({24'h0, small_o}, 32'h0000_003c);
    $display("test selection done");
    // every area code with the select bit set; upper bits written as zero
    for (int i = 0; i < 4; i++)
    begin
      wr(fesrm_pkg::RAM_MAP_ADDR, {5'h01, i[1:0], 1'b1}, 4'h1);
      repeat (2) @(posedge sys_clk_i);
      check_val({emu_o, 7'h0, base_o}, {1'b1, 7'h0, 24'h000400 * i[23:0]});
      rd_check(fesrm_pkg::RAM_MAP_ADDR, {5'h1f, i[1:0], 1'b1}, {5'h1f, i[1:0], 1'b1});
    end
    wr(fesrm_pkg::RAM_MAP_ADDR, 8'h06, 4'h1);
    repeat (2) @(posedge sys_clk_i);
    check_val({emu_o, 7'h0, base_o}, {8'h0, fesrm_pkg::RAM_NORMAL_BASE});
    rd_check(fesrm_pkg::RAM_MAP_ADDR, 8'hf6, 8'hf6);
    rd(10'h300);
    check_resp(s_axi_rresp, fesrm_pkg::RESP_SLVERR);
    wr(10'h300, 8'h00, 4'h1);
    check_resp(s_axi_bresp, fesrm_pkg::RESP_SLVERR);
    $display("test mapping done");
    // flash disabled in mid-run without a reset
    op_mode_i <= 3'h3;
    repeat (6) @(posedge sys_clk_i);
    rd_check(fesrm_pkg::LARGE_SEL_ADDR, 8'hff, 8'h00);
    rd_check(fesrm_pkg::MODE_STATUS_ADDR, 8'h03, 8'h03);
    check_val({large_o, large_1}, 32'h0);
    $display("test mode_change done");
    summarize();
  end

  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    num_errors++;
    summarize();
  end
endmodule : fesrm_bench
